/* common/cmo_pkg.sv */
// Purpose: Constants for the CANopen master request/response mailbox
// Assumes: 50 MHz aclk, AXI4-Lite register access, 11-bit CAN identifiers
// Notes:   Identifiers are built from a 4-bit function code and a 7-bit node number
package cmo_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SDO_TIMEOUT_MS = 100;
    localparam int unsigned SDO_TIMEOUT_CYC = (CLK_HZ / 1000) * SDO_TIMEOUT_MS;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] REQ_WIN_BASE = 12'h000;
    localparam logic [11:0] RESP_WIN_BASE = 12'h080;
    localparam logic [11:0] SYNC_PERIOD_ADDR = 12'h100;
    localparam logic [11:0] EMCY_CTRL_ADDR = 12'h104;
    localparam logic [11:0] BLOCK_STATUS_ADDR = 12'h108;
    localparam logic [11:0] OWN_NODE_ADDR = 12'h10c;
    localparam logic [11:0] RX_EMCY_ADDR = 12'h110;
    localparam int WIN_WORDS = 32;
    localparam int RESP_USED = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Request / response field values
    // ------------------------------------------------------------
    localparam logic [7:0] REQ_COMMAND = 8'h01;
    localparam logic [7:0] ACC_READ = 8'h01;
    localparam logic [7:0] ACC_WRITE = 8'h02;
    localparam logic [7:0] SIZE_READ = 8'h04;
    localparam logic [7:0] SIZE_WR_DWORD = 8'h08;
    localparam logic [7:0] SIZE_WR_WORD = 8'h06;
    localparam logic [7:0] SIZE_WR_BYTE = 8'h05;
    localparam logic [7:0] ST_NONE = 8'h00;
    localparam logic [7:0] ST_SUCCESS = 8'h01;
    localparam logic [7:0] ST_BUSY = 8'h02;
    localparam logic [7:0] ST_TIMEOUT = 8'h03;
    localparam logic [7:0] ST_BAD_CMD = 8'h04;
    localparam logic [7:0] ST_BAD_TX_LEN = 8'h05;
    localparam logic [7:0] ST_BAD_RX_LEN = 8'h06;
    localparam logic [7:0] ST_TARGET_BUSY = 8'h07;
    localparam logic [7:0] ST_BAD_TYPE = 8'h08;
    localparam logic [7:0] ST_BAD_NODE = 8'h09;
    localparam logic [7:0] ST_ABORT = 8'h0a;
    // ------------------------------------------------------------
    // Service data codes
    // ------------------------------------------------------------
    localparam logic [7:0] SDO_WR4 = 8'h23;
    localparam logic [7:0] SDO_WR2 = 8'h2b;
    localparam logic [7:0] SDO_WR1 = 8'h2f;
    localparam logic [7:0] SDO_RD = 8'h40;
    localparam logic [7:0] SDO_ABORT = 8'h80;
    localparam logic [7:0] SDO_RD4 = 8'h43;
    localparam logic [7:0] SDO_RD2 = 8'h4b;
    localparam logic [7:0] SDO_RD1 = 8'h4f;
    localparam logic [7:0] SDO_WR_ACK = 8'h60;
    // ------------------------------------------------------------
    // Function codes of the predefined connection set
    // ------------------------------------------------------------
    localparam logic [3:0] FC_NMT = 4'h0;
    localparam logic [3:0] FC_SYNC_EMCY = 4'h1;
    localparam logic [3:0] FC_TIME = 4'h2;
    localparam logic [3:0] FC_PDO1_TX = 4'h3;
    localparam logic [3:0] FC_PDO1_RX = 4'h4;
    localparam logic [3:0] FC_SDO_TX = 4'hb;
    localparam logic [3:0] FC_SDO_RX = 4'hc;
    localparam logic [3:0] FC_ERR_CTRL = 4'he;
    localparam logic [6:0] NODE_MAX = 7'h7f;
    localparam logic [3:0] DLC_SYNC = 4'h0;
    localparam logic [3:0] DLC_FULL = 4'h8;
    typedef enum logic [1:0] {SRC_NONE = 2'b00, SRC_SYNC = 2'b01, SRC_EMCY = 2'b10,
                              SRC_SDO = 2'b11} cmo_src_type;
    typedef enum logic [1:0] {FL_IDLE = 2'b00, FL_SEND = 2'b01,
                              FL_WAIT = 2'b10} cmo_flow_type;
    // Identifier = function code in bits 10:7, node number in bits 6:0
    function automatic logic [10:0] cmo_cob_id(input logic [3:0] fc, input logic [6:0] node);
        return {fc, node};
    endfunction : cmo_cob_id
endpackage : cmo_pkg

/* design/cmo_mailbox.sv */
// Purpose: CANopen master mailbox: request window in, SDO/SYNC/EMCY frames out
// Assumes: Frame-level CAN controller outside; inputs synchronous to aclk
// Notes:   One request in flight at a time; tag changes are picked up when idle
//
// Overview of operation
// - Broadcast SYNC periodically on identifier 80h, no node offset added.
// - On internal error, send emergency frame with code and enter error state.
// - After error clears, send emergency with code zero and return to normal.
// - Emergency frame: 80h plus node, code LSB first, error register, detail.
// - Error register byte: 0 none, 1 generic, 80h internal.
// - Identifiers are 11 bits: 4-bit function code plus node number.
// - Broadcast identifiers fixed: management 0, SYNC 80h, time stamp 100h.
// - Node identifiers are per-object bases plus node number.
// - Request and response windows of 32 sixteen-bit words each.
// - At most one outstanding request towards a node at a time.
// - Request words: command, tag, size, node, type, index, subindex, data.
// - A transfer starts only when the request tag value changes.
// - Access type 01 reads, 02 writes; node field picks the target.
// - Response words: status, tag, size, type, node, index, subindex, data.
// - Status codes: none, success, busy, timeout, errors, remote abort.
// - Response tag equals the tag of the producing request.
// - SDO request on 600h plus node with code, index, subindex, data.
`timescale 1ns/1ps
module cmo_mailbox
    import cmo_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = SDO_TIMEOUT_CYC
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CAN frame transmit
    output logic can_tx_valid,
    output logic [10:0] can_tx_id,
    output logic [3:0] can_tx_dlc,
    output logic [63:0] can_tx_data,
    input wire logic can_tx_ready,
    // CAN frame receive
    input wire logic can_rx_valid,
    input wire logic [10:0] can_rx_id,
    input wire logic [63:0] can_rx_data
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIN_WORDS-1:0][15:0] req_win;
        logic [RESP_USED-1:0][15:0] resp_win;
        cmo_flow_type flow;
        logic [7:0] last_tag;
        logic [6:0] cur_node;
        logic [7:0] cur_size;
        logic [31:0] timer;
        logic [31:0] sync_period;
        logic [31:0] sync_cnt;
        logic sync_pend;
        logic [15:0] emcy_code;
        logic [7:0] emcy_reg;
        logic emcy_pend;
        logic err_state;
        logic [6:0] own_node;
        logic [15:0] rx_emcy_code;
        logic [6:0] rx_emcy_node;
        logic tx_valid;
        logic [10:0] tx_id;
        logic [3:0] tx_dlc;
        logic [63:0] tx_data;
        cmo_src_type tx_src;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cmo_regs_type;

    cmo_regs_type s_ff;
    cmo_regs_type nxt_s;

    // Request fields as the host currently shows them
    logic [7:0] req_cmd;
    logic [7:0] req_tag;
    logic [7:0] req_size;
    logic [6:0] req_node;
    logic [7:0] req_type;
    logic [15:0] resp_word;
    logic [7:0] sdo_code;
    logic [7:0] rx_code;
    logic sync_tick;
    logic emcy_wr;

    assign req_cmd = s_ff.req_win[0][7:0];
    assign req_tag = s_ff.req_win[0][15:8];
    assign req_size = s_ff.req_win[1][7:0];
    assign req_node = s_ff.req_win[2][6:0];
    assign req_type = s_ff.req_win[2][15:8];
    assign rx_code = can_rx_data[7:0];
    // A pending flag may be set and taken in one cycle; the new event must win
    assign sync_tick = (s_ff.sync_period != 32'h0) &&
                       (s_ff.sync_cnt >= s_ff.sync_period - 32'h1);
    assign emcy_wr = s_ff.awready && (s_axi_awaddr == EMCY_CTRL_ADDR);

    // Response words beyond the used ones read as zero
    assign resp_word = (s_axi_araddr[6:2] < 5'(RESP_USED)) ?
                       s_ff.resp_win[s_axi_araddr[4:2]] : 16'h0000;

    // Write code chosen by the object width carried in the size field
    always_comb
    begin
        case (s_ff.cur_size)
            SIZE_WR_DWORD: sdo_code = SDO_WR4;
            SIZE_WR_WORD: sdo_code = SDO_WR2;
            SIZE_WR_BYTE: sdo_code = SDO_WR1;
            default: sdo_code = SDO_RD;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        // Bus slave: address and data taken together, one cycle of ready
        nxt_s.awready = 1'b0;
        nxt_s.wready = 1'b0;
        nxt_s.arready = 1'b0;
        if (s_ff.bvalid && s_axi_bready)
            nxt_s.bvalid = 1'b0;
        if (s_ff.rvalid && s_axi_rready)
            nxt_s.rvalid = 1'b0;
        if (!s_ff.bvalid && !s_ff.awready && s_axi_awvalid && s_axi_wvalid)
        begin
            nxt_s.awready = 1'b1;
            nxt_s.wready = 1'b1;
        end
        if (!s_ff.rvalid && !s_ff.arready && s_axi_arvalid)
            nxt_s.arready = 1'b1;

        // Register writes; response window and status are read-only
        if (s_ff.awready)
        begin
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = RESP_OKAY;
            if (s_axi_awaddr < RESP_WIN_BASE)
            begin
                if (s_axi_wstrb[0])
                    nxt_s.req_win[s_axi_awaddr[6:2]][7:0] = s_axi_wdata[7:0];
                if (s_axi_wstrb[1])
                    nxt_s.req_win[s_axi_awaddr[6:2]][15:8] = s_axi_wdata[15:8];
            end
            else if (s_axi_awaddr == SYNC_PERIOD_ADDR)
                nxt_s.sync_period = s_axi_wdata;
            else if (s_axi_awaddr == EMCY_CTRL_ADDR)
            begin
                // Code nonzero reports an error, zero reports recovery
                nxt_s.emcy_code = s_axi_wdata[15:0];
                nxt_s.emcy_reg = s_axi_wdata[23:16];
                nxt_s.emcy_pend = 1'b1;
            end
            else if (s_axi_awaddr == OWN_NODE_ADDR)
                nxt_s.own_node = s_axi_wdata[6:0];
            else if (s_axi_awaddr[11:7] != REQ_WIN_BASE[11:7] &&
                     s_axi_awaddr[11:7] != RESP_WIN_BASE[11:7] &&
                     s_axi_awaddr != BLOCK_STATUS_ADDR && s_axi_awaddr != RX_EMCY_ADDR)
                nxt_s.bresp = RESP_SLVERR;
        end

        // Register reads
        if (s_ff.arready)
        begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            nxt_s.rdata = 32'h0;
            if (s_axi_araddr < RESP_WIN_BASE)
                nxt_s.rdata = {16'h0000, s_ff.req_win[s_axi_araddr[6:2]]};
            else if (s_axi_araddr < SYNC_PERIOD_ADDR)
                nxt_s.rdata = {16'h0000, resp_word};
            else if (s_axi_araddr == SYNC_PERIOD_ADDR)
                nxt_s.rdata = s_ff.sync_period;
            else if (s_axi_araddr == EMCY_CTRL_ADDR)
                nxt_s.rdata = {8'h00, s_ff.emcy_reg, s_ff.emcy_code};
            else if (s_axi_araddr == BLOCK_STATUS_ADDR)
                nxt_s.rdata = {28'h0, s_ff.sync_pend, s_ff.emcy_pend, s_ff.err_state,
                               s_ff.flow != FL_IDLE};
            else if (s_axi_araddr == OWN_NODE_ADDR)
                nxt_s.rdata = {25'h0, s_ff.own_node};
            else if (s_axi_araddr == RX_EMCY_ADDR)
                nxt_s.rdata = {9'h000, s_ff.rx_emcy_node, s_ff.rx_emcy_code};
            else
                nxt_s.rresp = RESP_SLVERR;
        end

        // Periodic SYNC request; a period of zero stops it
        if (s_ff.sync_period == 32'h0)
            nxt_s.sync_cnt = 32'h0;
        else if (s_ff.sync_cnt >= s_ff.sync_period - 32'h1)
        begin
            nxt_s.sync_cnt = 32'h0;
            nxt_s.sync_pend = 1'b1;
        end
        else
            nxt_s.sync_cnt = s_ff.sync_cnt + 32'h1;

        // Emergencies seen from remote nodes are kept for software
        if (can_rx_valid && can_rx_id[10:7] == FC_SYNC_EMCY && can_rx_id[6:0] != 7'h00)
        begin
            nxt_s.rx_emcy_code = can_rx_data[15:0];
            nxt_s.rx_emcy_node = can_rx_id[6:0];
        end

        // Request flow
        case (s_ff.flow)
            FL_IDLE:
            begin
                // Only a changed tag starts work, so a stale window never resends
                if (req_tag != s_ff.last_tag)
                begin
                    nxt_s.last_tag = req_tag;
                    nxt_s.cur_node = req_node;
                    nxt_s.cur_size = req_size;
                    nxt_s.resp_win = '0;
                    nxt_s.resp_win[2] = {8'h00, 1'b0, req_node};
                    nxt_s.resp_win[0] = {req_tag, ST_BUSY};
                    nxt_s.flow = FL_SEND;
                    nxt_s.timer = 32'h0;
                    // Checks in order of precedence
                    if (req_cmd != REQ_COMMAND)
                        nxt_s.resp_win[0][7:0] = ST_BAD_CMD;
                    else if (req_type != ACC_READ && req_type != ACC_WRITE)
                        nxt_s.resp_win[0][7:0] = ST_BAD_TYPE;
                    else if ((req_type == ACC_READ && req_size != SIZE_READ) ||
                             (req_type == ACC_WRITE && req_size != SIZE_WR_DWORD &&
                              req_size != SIZE_WR_WORD && req_size != SIZE_WR_BYTE))
                        nxt_s.resp_win[0][7:0] = ST_BAD_TX_LEN;
                    else if (req_node == 7'h00)
                        nxt_s.resp_win[0][7:0] = ST_BAD_NODE;
                    if (nxt_s.resp_win[0][7:0] != ST_BUSY)
                        nxt_s.flow = FL_IDLE;
                end
            end
            FL_SEND:
            begin
                if (s_ff.tx_valid && can_tx_ready && s_ff.tx_src == SRC_SDO)
                    nxt_s.flow = FL_WAIT;
            end
            FL_WAIT:
            begin
                nxt_s.timer = s_ff.timer + 32'h1;
                if (can_rx_valid && can_rx_id == cmo_cob_id(FC_SDO_TX, s_ff.cur_node))
                begin
                    nxt_s.flow = FL_IDLE;
                    nxt_s.resp_win[2] = {rx_code, 1'b0, s_ff.cur_node};
                    nxt_s.resp_win[3] = can_rx_data[23:8];
                    nxt_s.resp_win[4] = {8'h00, can_rx_data[31:24]};
                    nxt_s.resp_win[5] = can_rx_data[47:32];
                    nxt_s.resp_win[6] = can_rx_data[63:48];
                    nxt_s.resp_win[0][7:0] = ST_SUCCESS;
                    case (rx_code)
                        SDO_RD4: nxt_s.resp_win[1] = {8'h00, SIZE_WR_DWORD};
                        SDO_RD2: nxt_s.resp_win[1] = {8'h00, SIZE_WR_WORD};
                        SDO_RD1: nxt_s.resp_win[1] = {8'h00, SIZE_WR_BYTE};
                        SDO_WR_ACK: nxt_s.resp_win[1] = {8'h00, SIZE_READ};
                        SDO_ABORT: nxt_s.resp_win[0][7:0] = ST_ABORT;
                        default: nxt_s.resp_win[0][7:0] = ST_BAD_RX_LEN;
                    endcase
                end
                else if (s_ff.timer >= TIMEOUT_CYCLES - 1)
                begin
                    nxt_s.flow = FL_IDLE;
                    nxt_s.resp_win[0][7:0] = ST_TIMEOUT;
                end
            end
            default: nxt_s.flow = FL_IDLE;
        endcase

        // Transmit port: release on acceptance, then load by priority
        if (s_ff.tx_valid && can_tx_ready)
        begin
            nxt_s.tx_valid = 1'b0;
            if (s_ff.tx_src == SRC_EMCY)
                nxt_s.err_state = s_ff.tx_data[15:0] != 16'h0000;
        end
        if (!s_ff.tx_valid)
        begin
            if (s_ff.emcy_pend)
            begin
                nxt_s.emcy_pend = emcy_wr;
                nxt_s.tx_valid = 1'b1;
                nxt_s.tx_src = SRC_EMCY;
                nxt_s.tx_id = cmo_cob_id(FC_SYNC_EMCY, s_ff.own_node);
                nxt_s.tx_dlc = DLC_FULL;
                nxt_s.tx_data = {40'h0, s_ff.emcy_reg, s_ff.emcy_code};
            end
            else if (s_ff.flow == FL_SEND)
            begin
                nxt_s.tx_valid = 1'b1;
                nxt_s.tx_src = SRC_SDO;
                nxt_s.tx_id = cmo_cob_id(FC_SDO_RX, s_ff.cur_node);
                nxt_s.tx_dlc = DLC_FULL;
                nxt_s.tx_data = {s_ff.req_win[6], s_ff.req_win[5], s_ff.req_win[4][7:0],
                                 s_ff.req_win[3], sdo_code};
            end
            else if (s_ff.sync_pend)
            begin
                nxt_s.sync_pend = sync_tick;
                nxt_s.tx_valid = 1'b1;
                nxt_s.tx_src = SRC_SYNC;
                nxt_s.tx_id = cmo_cob_id(FC_SYNC_EMCY, 7'h00);
                nxt_s.tx_dlc = DLC_SYNC;
                nxt_s.tx_data = 64'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset; every field starts at zero, SYNC disabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = s_ff.awready;
    assign s_axi_wready = s_ff.wready;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = s_ff.arready;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rdata = s_ff.rdata;
    assign s_axi_rresp = s_ff.rresp;
    assign can_tx_valid = s_ff.tx_valid;
    assign can_tx_id = s_ff.tx_id;
    assign can_tx_dlc = s_ff.tx_dlc;
    assign can_tx_data = s_ff.tx_data;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sync_frame;
        s_ff.tx_valid && s_ff.tx_src == SRC_SYNC |-> s_ff.tx_id == 11'h080 && s_ff.tx_dlc == 4'h0;
    endproperty
    a_sync_frame: assert property (p_sync_frame) else $error("SYNC frame id or length wrong");

    property p_emcy_frame;
        s_ff.tx_valid && s_ff.tx_src == SRC_EMCY |->
            s_ff.tx_id == 11'h080 + {4'h0, s_ff.own_node} && s_ff.tx_data[23:16] == s_ff.emcy_reg;
    endproperty
    a_emcy_frame: assert property (p_emcy_frame) else $error("Emergency frame layout wrong");

    property p_sdo_frame;
        s_ff.tx_valid && s_ff.tx_src == SRC_SDO |->
            s_ff.tx_id == 11'h600 + {4'h0, s_ff.cur_node} && s_ff.tx_data[23:8] == s_ff.req_win[3];
    endproperty
    a_sdo_frame: assert property (p_sdo_frame) else $error("SDO request frame wrong");

    property p_busy_status;
        s_ff.flow == FL_WAIT |-> s_ff.resp_win[0][7:0] == 8'h02;
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("Status not busy while waiting");

    property p_tag_echo;
        $rose(s_ff.flow == FL_SEND) |-> s_ff.resp_win[0][15:8] == $past(req_tag);
    endproperty
    a_tag_echo: assert property (p_tag_echo) else $error("Response tag differs from request");

    property p_no_retrigger;
        s_ff.flow == FL_IDLE && req_tag == s_ff.last_tag |=> s_ff.flow == FL_IDLE;
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("Transfer without tag change");

    property p_bad_type;
        s_ff.flow == FL_IDLE && req_tag != s_ff.last_tag && req_cmd == 8'h01 &&
            req_type != 8'h01 && req_type != 8'h02
        |=> s_ff.flow == FL_IDLE && s_ff.resp_win[0][7:0] == 8'h08 ##1 !(s_ff.tx_src == SRC_SDO && s_ff.tx_valid);
    endproperty
    a_bad_type: assert property (p_bad_type) else $error("Bad type not rejected");

    property p_err_state;
        s_ff.tx_valid && can_tx_ready && s_ff.tx_src == SRC_EMCY
        |=> s_ff.err_state == ($past(s_ff.tx_data[15:0]) != 16'h0);
    endproperty
    a_err_state: assert property (p_err_state) else $error("Error state does not follow emergency");

    property p_one_outstanding;
        s_ff.flow == FL_WAIT |-> !(s_ff.tx_valid && s_ff.tx_src == SRC_SDO);
    endproperty
    a_one_outstanding: assert property (p_one_outstanding) else $error("Second request while waiting");

    c_sdo_ok: cover property (s_ff.flow == FL_WAIT ##1 s_ff.resp_win[0][7:0] == 8'h01);
    c_timeout: cover property (s_ff.flow == FL_WAIT ##1 s_ff.resp_win[0][7:0] == 8'h03);
    c_sync_sent: cover property (s_ff.tx_valid && can_tx_ready && s_ff.tx_src == SRC_SYNC);
    c_emcy_clear: cover property (s_ff.err_state ##[1:50] !s_ff.err_state);
endmodule : cmo_mailbox

/* verif/cmo_remote_node.sv */
// Purpose: Remote CANopen node answering service data requests
// Assumes: Frame-level port of the mailbox, one clock
// Notes:   Mute drops replies so the mailbox can time out
`timescale 1ns/1ps
module cmo_remote_node (
    // Clock and control
    input logic aclk,
    input logic mute,
    // Frames from the mailbox
    input logic tx_valid,
    input logic [10:0] tx_id,
    input logic [63:0] tx_data,
    output logic tx_ready = 1'b0,
    // Frames to the mailbox
    output logic rx_valid = 1'b0,
    output logic [10:0] rx_id = 11'h000,
    output logic [63:0] rx_data = 64'h0,
    // Write data put into effect at the latest SYNC
    output logic [31:0] applied = 32'h0
);
    logic pv = 1'b0;
    logic [31:0] held = 32'h0;
    logic [10:0] pid;
    logic [63:0] pd;
    // Accept one cycle late; idle lines toggle so stale data never looks valid
    always @(posedge aclk)
    begin
        tx_ready <= tx_valid & !tx_ready;
        rx_valid <= pv;
        rx_id <= pv ? pid : ~rx_id;
        rx_data <= pv ? pd : ~rx_data;
        pv <= tx_valid & tx_ready & (tx_id[10:7] == 4'hc) & !mute;
        pid <= {4'hb, tx_id[6:0]};
        pd <= {32'h11223344, tx_data[31:8], tx_data[7:0] == 8'h40 ? 8'h43 : 8'h60};
        // Synchronous node: a written value waits for the next SYNC
        if (tx_valid & tx_ready & (tx_id[10:7] == 4'hc) & (tx_data[7:0] != 8'h40))
            held <= tx_data[63:32];
        if (tx_valid & tx_ready & (tx_id == 11'h080))
            applied <= held;
    end
endmodule : cmo_remote_node

/* verif/tb_top.sv */
// Purpose: Register-level tests of the mailbox
// Assumes: AXI4-Lite master tasks, remote node model
// Notes:   Short timeout parameter keeps the run brief
`timescale 1ns/1ps
module tb_top;
    import cmo_pkg::*;
    logic aclk = 0, aresetn = 0, aw = 0, w = 0, br = 0, ar = 0, rr = 0, mute = 0;
    logic awr, wr_, bv, arr, rv, txv, txr, rxv;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd_, v, app;
    logic [3:0] dlc, sdl;
    logic [1:0] bre, rre;
    logic [10:0] txi, rxi, sid;
    logic [63:0] txd, rxd, sd;
    int n_fail = 0, tests_run = 0, k, n_tx = 0;
    always #10 aclk = ~aclk;
    // Record every frame the node accepts
    always @(posedge aclk)
        if (txv && txr)
        begin
            sid <= txi;
            sd <= txd;
            sdl <= dlc;
            n_tx <= n_tx + 1;
        end
    cmo_mailbox #(.TIMEOUT_CYCLES(50)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(w), .s_axi_wready(wr_), .s_axi_bresp(bre),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(ar),
        .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rre), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .can_tx_valid(txv), .can_tx_id(txi), .can_tx_dlc(dlc),
        .can_tx_data(txd), .can_tx_ready(txr), .can_rx_valid(rxv), .can_rx_id(rxi),
        .can_rx_data(rxd));
    cmo_remote_node u_node (.aclk(aclk), .mute(mute), .tx_valid(txv), .tx_id(txi),
        .tx_data(txd), .tx_ready(txr), .rx_valid(rxv), .rx_id(rxi), .rx_data(rxd),
        .applied(app));
    task complete_run;
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task chk(input string n, input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a; wd <= d; aw <= 1; w <= 1; br <= 1;
        do @(posedge aclk); while (!(awr && wr_));
        aw <= 0; w <= 0;
        do @(posedge aclk); while (!bv);
        br <= 0;
    endtask : wr
    task rd(input logic [11:0] a);
        @(posedge aclk);
        ara <= a; ar <= 1; rr <= 1;
        do @(posedge aclk); while (!arr);
        ar <= 0;
        do @(posedge aclk); while (!rv);
        v = rd_;
        rr <= 0;
    endtask : rd
    // Clear the window, compose, then poll until its own tag shows a final status
    task req(input logic [15:0] w0, w1, w2, input logic [31:0] dt, input logic [7:0] st);
        for (int i = 0; i < WIN_WORDS; i++)
            wr(12'(i * 4), 0);
        wr(12'h00c, 32'h212d); wr(12'h014, dt[15:0]); wr(12'h018, dt[31:16]);
        wr(12'h004, w1); wr(12'h008, w2); wr(12'h000, w0);
        do rd(12'h080); while (v[7:0] == ST_BUSY || v[15:8] !== w0[15:8]);
        chk("resp0", v, {w0[15:8], st});
    endtask : req
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(12'h080); chk("rst", v, 0);
        rd(12'h200); chk("unmap", rre, RESP_SLVERR);
        req(16'h0101, 4, 16'h0103, 0, ST_SUCCESS);
        chk("sdoid", sid, 11'h603); chk("rcode", sd, 64'h00212d40);
        chk("sdlc", sdl, 8);
        rd(12'h084); chk("size", v, 8); rd(12'h094); chk("dlo", v, 32'h3344);
        req(16'h0201, 8, 16'h0203, 32'h010203e8, ST_SUCCESS);
        chk("wdat", sd, 64'h0102_03e8_00212d23);
        rd(12'h088); chk("type", v, 32'h6003);
        req(16'h0301, 4, 16'h0503, 0, ST_BAD_TYPE);
        req(16'h0401, 5, 16'h0103, 0, ST_BAD_TX_LEN);
        req(16'h0602, 4, 16'h0103, 0, ST_BAD_CMD);
        req(16'h0701, 4, 16'h0100, 0, ST_BAD_NODE);
        mute <= 1; req(16'h0501, 4, 16'h0103, 0, ST_TIMEOUT); mute <= 0;
        wr(12'h000, 32'h0501); rd(12'h080); chk("same", v, 32'h0503);
        wr(12'h10c, 5); k = n_tx; wr(12'h104, 32'h801234); wait (n_tx != k);
        chk("emid", sid, 11'h085); chk("emdat", sd, 64'h801234);
        chk("edlc", sdl, 8);
        rd(12'h108); chk("errst", v[1], 1);
        k = n_tx; wr(12'h104, 0); wait (n_tx != k); chk("clr", sd[23:0], 0);
        rd(12'h108); chk("norm", v[1], 0);
        k = n_tx; wr(12'h100, 30); wait (n_tx != k); chk("sync", sid, 11'h080);
        chk("sydlc", sdl, 0);
        wr(12'h100, 0); chk("apply", app, 32'h010203e8);
        complete_run();
    end
    // Cut a hang short well past the expected run length
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        complete_run();
    end
endmodule : tb_top
